//--- spd_pkg.sv
/*
 * constants and carrier types for the special function register page decoder.
 * assumes one system clock and a core that issues one direct access per cycle at most.
 */
package spd_pkg;

    // address window and page register
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [7:0] PAGE_SEL_ADDR = 8'hBF;
    localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
    localparam int PAGE_COUNT = 256;
    // populated pages
    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam logic [7:0] PAGE_F = 8'h0F;
    // low address bits that mark a bit-addressable location
    localparam logic [2:0] BIT_ADDR_LOW = 3'h0;
    // byte write mask
    localparam logic [7:0] FULL_MASK = 8'hFF;
    // locations that hold a separate register per page
    localparam int PAGED_COUNT = 16;
    localparam logic [7:0] PAGED_LOCS [PAGED_COUNT] = '{
        8'h91, 8'h92, 8'h93, 8'h94, 8'h95,
        8'hB9,
        8'hC0, 8'hC1, 8'hC2,
        8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE, 8'hCF
    };
    localparam logic [7:0] PAGED_LOC_E4 = 8'hE4;

    // one direct access from the core
    typedef struct packed {
        logic valid;      // access present this cycle
        logic write;      // 1 write, 0 read
        logic bitMode;    // bitwise instruction
        logic [2:0] bitIdx;
        logic [7:0] addr;
        logic [7:0] wdata; // byte data, or bit value in bit 0
    } spd_req_t;

    // answer to the core
    typedef struct packed {
        logic ack;        // one-cycle pulse
        logic sfrHit;     // access was claimed as register access
        logic refused;    // bit access to byte-only location
        logic [7:0] rdata;
    } spd_rsp_t;

    // strobe toward the peripherals
    typedef struct packed {
        logic sel;        // one-cycle pulse
        logic write;
        logic bank;       // 0 page-0 or shared register, 1 page-F register
        logic [7:0] addr;
        logic [7:0] wmask;
        logic [7:0] wdata;
    } spd_tgt_t;

    // decode result of one address
    typedef struct packed {
        logic inWindow;
        logic isPageReg;
        logic reachable;
        logic bank;
        logic bitOk;
    } spd_dec_t;

endpackage : spd_pkg

//--- spd_page_map.sv
/*
 * combinational map of one direct address and page to a register target.
 * assumes the page value is the live page register content.
 */
`timescale 1ns/1ns
module spd_page_map
(
    // address and page in
    input wire logic [7:0] addr,
    input wire logic [7:0] page,
    // decode out
    output spd_pkg::spd_dec_t dec
);

    // location carries a distinct register per page
    function automatic logic isPaged(input logic [7:0] a);
        logic hit;
        hit = (a == spd_pkg::PAGED_LOC_E4);
        for (int i = 0; i < spd_pkg::PAGED_COUNT; i++)
        begin
            if (a == spd_pkg::PAGED_LOCS[i])
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : isPaged

    logic pagePop; // page value is one of the populated two

    // decode the address against the whole 8-bit page
    always_comb
    begin
        pagePop = (page == spd_pkg::PAGE_ZERO) || (page == spd_pkg::PAGE_F);
        dec.inWindow = (addr >= spd_pkg::SFR_BASE);
        dec.isPageReg = dec.inWindow && (addr == spd_pkg::PAGE_SEL_ADDR);
        // page register answers on every page value, others only on populated ones
        dec.reachable = dec.inWindow && (dec.isPageReg || pagePop);
        // shared locations stay in bank 0 whichever page is active
        dec.bank = isPaged(addr) && (page == spd_pkg::PAGE_F);
        dec.bitOk = (addr[2:0] == spd_pkg::BIT_ADDR_LOW);
    end

endmodule : spd_page_map

//--- spd_sfr_page_decoder.sv
/*
 * page-select decoder for the special function register window.
 * holds the page register and routes core direct accesses to peripherals.
 * assumes peripherals return read data combinationally in the strobe cycle.
 */
`timescale 1ns/1ns
module spd_sfr_page_decoder
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // core direct access port
    input spd_pkg::spd_req_t coreReq,
    output spd_pkg::spd_rsp_t coreRsp,
    // peripheral target port
    output spd_pkg::spd_tgt_t tgt,
    input wire logic [7:0] tgtRdata,
    // live page for observation
    output logic [7:0] pageSel
);

    logic [7:0] pageSel_r;        // active page
    spd_pkg::spd_dec_t dec;       // decode of the incoming access
    spd_pkg::spd_tgt_t tgt_r;     // registered strobe
    spd_pkg::spd_rsp_t rsp_r;     // registered answer
    logic pend_r;                 // access taken last cycle, answer due
    logic pendBit_r;              // pending access is a bitwise access
    logic [2:0] pendIdx_r;        // bit index of pending read
    logic pendHit_r;              // pending access reached a peripheral
    logic pendLocal_r;            // pending answer is local, no peripheral
    logic [7:0] pendLocalData_r;  // local read data
    logic pendClaim_r;            // pending access was in window
    logic pendRef_r;              // pending access refused
    logic bitBad;                 // bit access to byte-only location
    logic [7:0] bitMask;          // one-hot mask for bit writes

    spd_page_map u_map
    (
        .addr(coreReq.addr),
        .page(pageSel_r),
        .dec(dec)
    );

    // a bit instruction at a byte-only location is refused, nothing is touched
    always_comb
    begin
        bitBad = coreReq.bitMode && !dec.bitOk;
        bitMask = 8'h01 << coreReq.bitIdx;
    end

    // page register; a write lands at this edge so the next access sees it
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pageSel_r <= spd_pkg::PAGE_SEL_RESET;
        end
        else if (coreReq.valid && coreReq.write && dec.isPageReg && !bitBad)
        begin
            pageSel_r <= coreReq.wdata;
        end
    end

    // strobe toward peripherals, one cycle after the request
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            tgt_r <= '0;
        end
        else
        begin
            tgt_r.sel <= coreReq.valid && dec.reachable && !dec.isPageReg && !bitBad;
            tgt_r.write <= coreReq.write;
            tgt_r.bank <= dec.bank;
            tgt_r.addr <= coreReq.addr;
            // bit writes touch one lane only, value taken from bit 0
            if (coreReq.bitMode)
            begin
                tgt_r.wmask <= bitMask;
                tgt_r.wdata <= {8{coreReq.wdata[0]}};
            end
            else
            begin
                tgt_r.wmask <= spd_pkg::FULL_MASK;
                tgt_r.wdata <= coreReq.wdata;
            end
        end
    end

    // bookkeeping for the answer that follows the strobe
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pend_r <= 1'b0;
            pendBit_r <= 1'b0;
            pendIdx_r <= 3'h0;
            pendHit_r <= 1'b0;
            pendLocal_r <= 1'b0;
            pendLocalData_r <= 8'h00;
            pendClaim_r <= 1'b0;
            pendRef_r <= 1'b0;
        end
        else
        begin
            pend_r <= coreReq.valid;
            pendBit_r <= coreReq.bitMode;
            pendIdx_r <= coreReq.bitIdx;
            pendHit_r <= dec.reachable && !dec.isPageReg && !bitBad;
            pendLocal_r <= dec.isPageReg;
            // page value after any write in the same cycle is what a read shows
            pendLocalData_r <= (coreReq.write && !bitBad) ? coreReq.wdata : pageSel_r;
            pendClaim_r <= dec.inWindow;
            pendRef_r <= bitBad;
        end
    end

    // answer to the core; unreached and refused locations read as zero
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            rsp_r <= '0;
        end
        else
        begin
            rsp_r.ack <= pend_r;
            rsp_r.sfrHit <= pend_r && pendClaim_r;
            rsp_r.refused <= pend_r && pendRef_r;
            if (!pend_r || pendRef_r)
            begin
                rsp_r.rdata <= 8'h00;
            end
            else if (pendLocal_r)
            begin
                rsp_r.rdata <= pendLocalData_r;
            end
            else if (pendHit_r && pendBit_r)
            begin
                // bit read returns the chosen bit in bit 0
                rsp_r.rdata <= {7'h00, tgtRdata[pendIdx_r]};
            end
            else if (pendHit_r)
            begin
                rsp_r.rdata <= tgtRdata;
            end
            else
            begin
                // page with no registers, or below the window
                rsp_r.rdata <= 8'h00;
            end
        end
    end

    assign coreRsp = rsp_r;
    assign tgt = tgt_r;
    assign pageSel = pageSel_r;

endmodule : spd_sfr_page_decoder

//--- spd_monitor.sv
/* port checker for the page decoder, bound to its top module.
   assumes one clock and a synchronous reset. */
`timescale 1ns/1ns
module spd_monitor
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // watched ports
    input spd_pkg::spd_req_t coreReq,
    input spd_pkg::spd_rsp_t coreRsp,
    input spd_pkg::spd_tgt_t tgt,
    input wire logic [7:0] tgtRdata,
    input wire logic [7:0] pageSel
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // page reaches real registers
    wire popPage = pageSel == spd_pkg::PAGE_ZERO || pageSel == spd_pkg::PAGE_F;
    // request in the window, not the page register
    wire inWin = coreReq.valid && coreReq.addr[7] && coreReq.addr != spd_pkg::PAGE_SEL_ADDR;
    wire pgAcc = coreReq.valid && !coreReq.bitMode && coreReq.addr == spd_pkg::PAGE_SEL_ADDR;
    // refused answer takes two steps
    sequence s_refused;
        !tgt.sel ##1 (coreRsp.ack && coreRsp.refused && coreRsp.rdata == 8'h00);
    endsequence
    property p_strobe;
        inWin && popPage && !coreReq.bitMode |=> tgt.sel && tgt.addr == $past(coreReq.addr);
    endproperty
    a_strobe: assert property (p_strobe) else $error("no strobe");
    property p_ack;
        coreReq.valid |-> ##2 coreRsp.ack;
    endproperty
    a_ack: assert property (p_ack) else $error("no answer");
    property p_low;
        coreReq.valid && !coreReq.addr[7] |=> !tgt.sel ##1 !coreRsp.sfrHit;
    endproperty
    a_low: assert property (p_low) else $error("low address claimed");
    property p_pageWr;
        pgAcc && coreReq.write |=> pageSel == $past(coreReq.wdata);
    endproperty
    a_pageWr: assert property (p_pageWr) else $error("page not taken");
    property p_pageRd;
        pgAcc && !coreReq.write |-> ##2 coreRsp.rdata == $past(pageSel, 2);
    endproperty
    a_pageRd: assert property (p_pageRd) else $error("page read wrong");
    property p_bank;
        tgt.sel && tgt.bank |-> $past(pageSel) == spd_pkg::PAGE_F;
    endproperty
    a_bank: assert property (p_bank) else $error("bank off page");
    property p_refuse;
        coreReq.valid && coreReq.bitMode && coreReq.addr[2:0] != 3'h0 |=> s_refused;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bit access let in");
    property p_unpop;
        inWin && !popPage |=> !tgt.sel;
    endproperty
    a_unpop: assert property (p_unpop) else $error("empty page strobed");
    property p_bitWr;
        inWin && popPage && coreReq.write && coreReq.bitMode && coreReq.addr[2:0] == 3'h0
            |=> tgt.wmask == 8'h01 << $past(coreReq.bitIdx);
    endproperty
    a_bitWr: assert property (p_bitWr) else $error("bit mask wrong");
endmodule : spd_monitor

bind spd_sfr_page_decoder spd_monitor mon (.clock(clock), .reset(reset), .coreReq(coreReq),
    .coreRsp(coreRsp), .tgt(tgt), .tgtRdata(tgtRdata), .pageSel(pageSel));

//--- spd_periph_model.sv
/* peripheral registers behind the decoder.
   assumes read data is sampled only while the strobe is high. */
`timescale 1ns/1ns
module spd_periph_model
(
    // strobe in
    input spd_pkg::spd_tgt_t tgt,
    // read data out
    output logic [7:0] tgtRdata
);
    // a register reads as its address, page-F bank flips bit 0
    // outside a strobe the bus shows the inverted address, never held data
    always_comb
        tgtRdata = tgt.sel ? (tgt.addr ^ {7'h0, tgt.bank}) : ~tgt.addr;
endmodule : spd_periph_model

//--- spd_sfr_page_decoder_tb.sv
/* testbench for the page decoder.
   assumes the peripheral model answers within the strobe cycle. */
`timescale 1ns/1ns
`define CHK(n, e, a) begin nCompared++; if ((a) !== (e)) begin errCount++; \
    $display("wrong value %s exp %h got %h", n, e, a); end end
module spd_sfr_page_decoder_tb;
    logic clock = 1'b0;
    logic reset = 1'b1;
    spd_pkg::spd_req_t req = '0;
    spd_pkg::spd_rsp_t rsp;
    spd_pkg::spd_tgt_t tgt;
    spd_pkg::spd_tgt_t sTgt; // strobe seen one cycle after request
    logic [7:0] rdata;
    logic [7:0] pageSel;
    int errCount = 0;
    int nCompared = 0;
    spd_sfr_page_decoder uut (.clock(clock), .reset(reset), .coreReq(req), .coreRsp(rsp),
        .tgt(tgt), .tgtRdata(rdata), .pageSel(pageSel));
    spd_periph_model periph (.tgt(tgt), .tgtRdata(rdata));
    initial forever #50 clock = ~clock;
    task summarize;
        if (errCount == 0 && nCompared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // one access; the strobe stands one cycle and the answer the next, so
    // the strobe is captured at the first falling edge and the answer still
    // stands on rsp when the task returns at the second
    task acc(input logic w, input logic b, input logic [2:0] i, input logic [7:0] a,
        input logic [7:0] d);
        req = '{1'b1, w, b, i, a, d};
        @(negedge clock);
        sTgt = tgt;
        req.valid = 1'b0;
        @(negedge clock);
    endtask : acc
    // reset in mid-run must drop a written page back to zero
    task t_midreset;
        acc(1'b1, 1'b0, 3'h0, 8'hBF, 8'h0F);
        reset = 1'b1;
        repeat (2) @(negedge clock);
        reset = 1'b0;
        `CHK("reset page", 8'h00, pageSel)
        @(negedge clock);
    endtask : t_midreset
    task t_reset;
        `CHK("page", 8'h00, pageSel)
        acc(1'b0, 1'b0, 3'h0, 8'hBF, 8'h00);
        `CHK("page rd", 8'h00, rsp.rdata)
    endtask : t_reset
    task t_paged;
        acc(1'b1, 1'b0, 3'h0, 8'hBF, 8'h0F); // page first
        `CHK("page wr", 8'h0F, rsp.rdata)
        acc(1'b0, 1'b0, 3'h0, 8'hC8, 8'h00);
        `CHK("rd F", 8'hC9, rsp.rdata)
        acc(1'b0, 1'b0, 3'h0, 8'hE0, 8'h00);
        `CHK("shared", 8'hE0, rsp.rdata)
        `CHK("hit", 1'b1, rsp.sfrHit)
        acc(1'b1, 1'b0, 3'h0, 8'hBF, 8'h00);
        acc(1'b0, 1'b0, 3'h0, 8'hC8, 8'h00);
        `CHK("rd 0", 8'hC8, rsp.rdata)
    endtask : t_paged
    // page write followed at once by a paged read
    task t_b2b;
        req = '{1'b1, 1'b1, 1'b0, 3'h0, 8'hBF, 8'h0F};
        @(negedge clock);
        req = '{1'b1, 1'b0, 1'b0, 3'h0, 8'hC8, 8'h00};
        @(negedge clock);
        req.valid = 1'b0;
        `CHK("b2b sel", 1'b1, tgt.sel)
        `CHK("b2b bank", 1'b1, tgt.bank)
        @(negedge clock);
        `CHK("b2b rd", 8'hC9, rsp.rdata)
    endtask : t_b2b
    task t_unpop;
        acc(1'b1, 1'b0, 3'h0, 8'hBF, 8'h8F);
        acc(1'b0, 1'b0, 3'h0, 8'hC8, 8'h00);
        `CHK("unpop sel", 1'b0, sTgt.sel)
        `CHK("unpop rd", 8'h00, rsp.rdata)
        acc(1'b0, 1'b0, 3'h0, 8'hBF, 8'h00);
        `CHK("page 8F", 8'h8F, rsp.rdata)
        acc(1'b1, 1'b0, 3'h0, 8'hBF, 8'h00); // write page back to 00
    endtask : t_unpop
    task t_bits;
        acc(1'b1, 1'b1, 3'h3, 8'hE8, 8'h01); // bit 3 of a bit-addressable location
        `CHK("bit wr", 1'b1, sTgt.write)
        `CHK("mask", 8'h08, sTgt.wmask)
        `CHK("bit data", 8'hFF, sTgt.wdata)
        acc(1'b0, 1'b1, 3'h3, 8'hE8, 8'h00);
        `CHK("bit rd", 8'h01, rsp.rdata)
        acc(1'b0, 1'b1, 3'h1, 8'hE9, 8'h00);
        `CHK("refused", 1'b1, rsp.refused)
        acc(1'b1, 1'b0, 3'h0, 8'hE9, 8'h5A);
        `CHK("byte mask", 8'hFF, sTgt.wmask)
    endtask : t_bits
    task t_low;
        acc(1'b0, 1'b0, 3'h0, 8'h40, 8'h00);
        `CHK("low ack", 1'b1, rsp.ack)
        `CHK("low hit", 1'b0, rsp.sfrHit)
        `CHK("low sel", 1'b0, sTgt.sel)
    endtask : t_low
    initial
    begin
        repeat (6) @(negedge clock);
        reset = 1'b0;
        repeat (2) @(negedge clock);
        t_reset;
        t_paged;
        t_b2b;
        t_midreset;
        t_unpop;
        t_bits;
        t_low;
        summarize;
    end
    initial
    begin
        #1000000;
        errCount++;
        summarize;
    end
endmodule : spd_sfr_page_decoder_tb
